// ---- hw/ndw_defs.svh ----
// Purpose: Offsets, field positions, write masks and reset values of the window bank.
// Assumes: Byte offsets inside the bridge control bank, one aligned word per register.
// Notes:   Bits outside a write mask are never stored and therefore read as zero.
`ifndef NDW_DEFS_SVH
`define NDW_DEFS_SVH

`define NDW_OFF_STATUS  12'h000
`define NDW_OFF_TB2     12'h008
`define NDW_OFF_SU2     12'h00C
`define NDW_OFF_TB3     12'h010
`define NDW_OFF_SU3     12'h014

`define NDW_RST_VAL     32'h0000_0000
`define NDW_TB_WMASK    32'hFFFF_F000
`define NDW_SU_WMASK    32'hFFFF_F00A
`define NDW_ST_WMASK    3'h7

`define NDW_SU_ADDR64   1
`define NDW_SU_TYPE_HI  2
`define NDW_SU_PREF     3
`define NDW_SU_SIZE_LO  12
`define NDW_SU_SIZE_HI  30
`define NDW_SU_EN       31

`define NDW_ST_WIN2     0
`define NDW_ST_WIN3     1
`define NDW_ST_MISS     2

`endif

// ---- hw/ndw_pkg.sv ----
// Purpose: Types shared by the downstream window bank and its helpers.
// Assumes: Both bridge ports present requests in the same request format.
// Notes:   A request is one cycle wide; its answer follows one cycle later.
package ndw_pkg;

    typedef struct packed {
        logic        valid;
        logic        io_space;
        logic        write;
        logic [11:0] offset;
        logic [31:0] wdata;
        logic [3:0]  byte_en;
    } ndw_req_type;

    typedef struct packed {
        logic        valid;
        logic [31:0] rdata;
    } ndw_rsp_type;

    typedef struct packed {
        logic        enable;
        logic [18:0] size_mask;
        logic        prefetch;
        logic        addr64;
    } ndw_win_cfg_type;

    typedef struct packed {
        logic        valid;
        logic        win3;
        logic [31:0] addr;
    } ndw_xreq_type;

    typedef struct packed {
        logic        valid;
        logic        hit;
        logic        win3;
        logic [31:0] addr;
    } ndw_xrsp_type;

endpackage

// ---- hw/ndw_win_regs.sv ----
// Purpose: Translated base and setup storage of one downstream window.
// Assumes: Write strobes are already decoded; the secondary write lands after the primary one.
// Notes:   Setup accepts secondary writes only, so a primary strobe is not even wired in.
`timescale 1ns/1ps
`include "ndw_defs.svh"
module ndw_win_regs
    import ndw_pkg::*;
(
    input  wire logic            clk,
    input  wire logic            sys_rst,
    input  wire logic            tb_wr_prim,
    input  wire logic            tb_wr_sec,
    input  wire logic            su_wr_sec,
    input  wire logic [31:0]     prim_wdata,
    input  wire logic [3:0]      prim_be,
    input  wire logic [31:0]     sec_wdata,
    input  wire logic [3:0]      sec_be,
    output logic      [31:0]     tbase,
    output logic      [31:0]     setup,
    output ndw_win_cfg_type      cfg
);

    logic [31:0] next_tbase;
    logic [31:0] next_setup;

    function automatic logic [31:0] merge(input logic [31:0] cur,
                                          input logic [31:0] wd,
                                          input logic [3:0]  be,
                                          input logic        en,
                                          input logic [31:0] wmask);
        logic [31:0] lane;
        lane = 32'h0000_0000;
        for (int i = 0; i < 4; i++) begin
            lane[8*i +: 8] = {8{be[i] & en}};
        end
        return (cur & ~(lane & wmask)) | (wd & lane & wmask);
    endfunction

    // Two writes in one cycle merge byte by byte, the secondary one on top.
    assign next_tbase = merge(merge(tbase, prim_wdata, prim_be, tb_wr_prim, `NDW_TB_WMASK),
                              sec_wdata, sec_be, tb_wr_sec, `NDW_TB_WMASK);
    // Only the secondary side can change setup; bit 0 and bits 11:4 stay zero.
    assign next_setup = merge(setup, sec_wdata, sec_be, su_wr_sec, `NDW_SU_WMASK);

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            tbase <= `NDW_RST_VAL;
            setup <= `NDW_RST_VAL;
        end else begin
            tbase <= next_tbase;
            setup <= next_setup;
        end
    end

    assign cfg.enable    = setup[`NDW_SU_EN];
    assign cfg.size_mask = setup[`NDW_SU_SIZE_HI:`NDW_SU_SIZE_LO];
    assign cfg.prefetch  = setup[`NDW_SU_PREF];
    assign cfg.addr64    = setup[`NDW_SU_ADDR64];

endmodule

// ---- hw/ndw_window_bank.sv ----
// Purpose: Downstream window 2 and 3 register bank of the non-transparent bridge.
// Assumes: Each bridge port hands over at most one request per cycle, in memory or I/O space.
// Notes:   Every request gets an answer on the next cycle; unmapped reads return zero.
//
// Functional notes
// - Memory and I/O requests from both the primary and the secondary port reach the bank.
// - Secondary-writable fields ignore primary writes, take secondary writes, read on both.
// - A write-one-clear bit clears where a one is written and keeps its value elsewhere.
// - Window 2 translated base is bits 31:12, read/write, zero after reset, used as new base.
// - The number of window 2 base bits used follows the size mask in its setup register.
// - Window 3 translated base is bits 31:12, read/write, zero after reset, used as new base.
// - The number of window 3 base bits used follows the size mask in its setup register.
// - Setup bit 0 reads zero for memory space; bit 3 selects prefetchable and resets to 0.
// - Setup bits 2:1 give 00 for a 32-bit and 01 for a 64-bit window, reset to 00.
// - Size mask bits 30:12 set which base bits are writable and so the window size; the code keeps base bits 31:12 writable and applies the mask in translation.
// - Setup bit 31 enables the window when one and disables it when zero, reset to 0.
`timescale 1ns/1ps
`include "ndw_defs.svh"
module ndw_window_bank
    import ndw_pkg::*;
(
    input  wire logic            clk,
    input  wire logic            sys_rst,
    input  wire ndw_req_type     prim_req,
    input  wire ndw_req_type     sec_req,
    output ndw_rsp_type          prim_rsp,
    output ndw_rsp_type          sec_rsp,
    input  wire ndw_xreq_type    dn_req,
    output ndw_xrsp_type         dn_xout,
    output ndw_win_cfg_type      win2_cfg,
    output ndw_win_cfg_type      win3_cfg
);

    localparam logic [11:0] OFF_ST  = `NDW_OFF_STATUS;
    localparam logic [11:0] OFF_TB2 = `NDW_OFF_TB2;
    localparam logic [11:0] OFF_SU2 = `NDW_OFF_SU2;
    localparam logic [11:0] OFF_TB3 = `NDW_OFF_TB3;
    localparam logic [11:0] OFF_SU3 = `NDW_OFF_SU3;
    localparam int          NPORT   = 2;
    localparam int          NWIN    = 2;

    // Port 0 is primary, port 1 is secondary.
    ndw_req_type     req_a   [NPORT];
    logic [4:0]      sel_a   [NPORT];
    logic [31:0]     rd_a    [NPORT];
    ndw_rsp_type     next_rsp[NPORT];
    ndw_rsp_type     rsp_q   [NPORT];
    logic [2:0]      clr_a   [NPORT];
    logic [31:0]     tb_q    [NWIN];
    logic [31:0]     su_q    [NWIN];
    ndw_win_cfg_type cfg_q   [NWIN];
    logic [2:0]      status;
    logic [2:0]      next_status;
    logic [2:0]      st_set;

    assign req_a[0] = prim_req;
    assign req_a[1] = sec_req;

    genvar p;
    generate
        for (p = 0; p < NPORT; p++) begin : g_port
            logic [9:0] word;
            logic       wr;
            // Address space does not matter, memory and I/O decode alike.
            assign word = req_a[p].offset[11:2];
            assign wr   = req_a[p].valid & req_a[p].write;
            assign sel_a[p] = {word == OFF_ST[11:2],  word == OFF_SU3[11:2],
                               word == OFF_TB3[11:2], word == OFF_SU2[11:2],
                               word == OFF_TB2[11:2]} & {5{req_a[p].valid}};
            assign rd_a[p] = sel_a[p][0] ? tb_q[0] :
                             sel_a[p][1] ? su_q[0] :
                             sel_a[p][2] ? tb_q[1] :
                             sel_a[p][3] ? su_q[1] :
                             sel_a[p][4] ? {29'h0000_0000, status} :
                             32'h0000_0000;
            assign clr_a[p] = (wr & sel_a[p][4] & req_a[p].byte_en[0]) ?
                              req_a[p].wdata[2:0] & `NDW_ST_WMASK : 3'h0;
            assign next_rsp[p].valid = req_a[p].valid;
            assign next_rsp[p].rdata = req_a[p].write ? 32'h0000_0000 : rd_a[p];

            always_ff @(posedge clk) begin
                if (sys_rst) begin
                    rsp_q[p] <= '0;
                end else begin
                    rsp_q[p] <= next_rsp[p];
                end
            end

            a_rsp_next: assert property (@(posedge clk) disable iff (sys_rst)
                req_a[p].valid && !req_a[p].write && req_a[p].offset[11:2] == OFF_TB2[11:2]
                |=> rsp_q[p].valid && rsp_q[p].rdata == $past(tb_q[0]))
                else $error("Read of window 2 base not answered next cycle.");
        end
    endgenerate

    genvar w;
    generate
        for (w = 0; w < NWIN; w++) begin : g_win
            ndw_win_regs u_regs (
                .clk        (clk),
                .sys_rst    (sys_rst),
                .tb_wr_prim (sel_a[0][2*w] & req_a[0].write),
                .tb_wr_sec  (sel_a[1][2*w] & req_a[1].write),
                .su_wr_sec  (sel_a[1][2*w+1] & req_a[1].write),
                .prim_wdata (req_a[0].wdata),
                .prim_be    (req_a[0].byte_en),
                .sec_wdata  (req_a[1].wdata),
                .sec_be     (req_a[1].byte_en),
                .tbase      (tb_q[w]),
                .setup      (su_q[w]),
                .cfg        (cfg_q[w])
            );
        end
    endgenerate

    ndw_xlate u_xlate (
        .clk     (clk),
        .sys_rst (sys_rst),
        .xreq    (dn_req),
        .tbase2  (tb_q[0]),
        .tbase3  (tb_q[1]),
        .cfg2    (cfg_q[0]),
        .cfg3    (cfg_q[1]),
        .xrsp    (dn_xout)
    );

    // A translation event landing with a clear keeps its bit; setting wins.
    assign st_set[`NDW_ST_WIN2] = dn_xout.valid & dn_xout.hit & ~dn_xout.win3;
    assign st_set[`NDW_ST_WIN3] = dn_xout.valid & dn_xout.hit & dn_xout.win3;
    assign st_set[`NDW_ST_MISS] = dn_xout.valid & ~dn_xout.hit;
    assign next_status = (status & ~(clr_a[0] | clr_a[1])) | st_set;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            status <= 3'h0;
        end else begin
            status <= next_status;
        end
    end

    assign prim_rsp = rsp_q[0];
    assign sec_rsp  = rsp_q[1];
    assign win2_cfg = cfg_q[0];
    assign win3_cfg = cfg_q[1];

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (sys_rst);

    a_prim_setup_ro: assert property (
        prim_req.valid && prim_req.write && prim_req.offset[11:2] == OFF_SU2[11:2]
        && !(sec_req.valid && sec_req.write && sec_req.offset[11:2] == OFF_SU2[11:2])
        |=> $stable(su_q[0]))
        else $error("Primary write changed window 2 setup.");

    a_w1c_clear: assert property (
        sec_req.valid && sec_req.write && sec_req.offset[11:2] == OFF_ST[11:2]
        && sec_req.byte_en[0] && sec_req.wdata[0] && !st_set[0] && !clr_a[0][0] |=> !status[0])
        else $error("Status bit not cleared by a one.");

    a_w1c_keep: assert property (
        status[1] && !clr_a[0][1] && !clr_a[1][1] |=> status[1])
        else $error("Status bit lost without a clearing one.");

    a_base2_write: assert property (
        prim_req.valid && prim_req.write && prim_req.offset[11:2] == OFF_TB2[11:2]
        && prim_req.byte_en == 4'hF && !sec_req.valid
        |=> tb_q[0] == {$past(prim_req.wdata[31:12]), 12'h000})
        else $error("Window 2 base not written from the primary port.");

    a_base3_write: assert property (
        sec_req.valid && sec_req.write && sec_req.offset[11:2] == OFF_TB3[11:2]
        && sec_req.byte_en == 4'hF |=> tb_q[1] == {$past(sec_req.wdata[31:12]), 12'h000})
        else $error("Window 3 base not written from the secondary port.");

    a_setup_fixed: assert property (
        su_q[0][0] == 1'b0 && su_q[0][11:4] == 8'h00 && su_q[1][0] == 1'b0)
        else $error("Fixed setup bits are not zero.");

    a_type_field: assert property (
        su_q[0][`NDW_SU_TYPE_HI] == 1'b0 && su_q[1][`NDW_SU_TYPE_HI] == 1'b0)
        else $error("Address type field holds an unsupported code.");

    a_size_write: assert property (
        sec_req.valid && sec_req.write && sec_req.offset[11:2] == OFF_SU3[11:2]
        && sec_req.byte_en == 4'hF |=> win3_cfg.size_mask == $past(sec_req.wdata[30:12]))
        else $error("Window 3 size mask not taken from a secondary write.");

    a_disabled_miss: assert property (
        dn_req.valid && !dn_req.win3 && !win2_cfg.enable |=> !dn_xout.hit ##1 status[2])
        else $error("Disabled window translated or miss not flagged.");

    a_rsp_prim: assert property (
        prim_req.valid
        |=> prim_rsp.valid)
        else $error("Primary request not answered on the next cycle.");

    a_rsp_sec: assert property (
        sec_req.valid
        |=> sec_rsp.valid)
        else $error("Secondary request not answered on the next cycle.");

    a_rsp_quiet: assert property (
        !prim_req.valid && !sec_req.valid
        |=> !prim_rsp.valid && !sec_rsp.valid)
        else $error("Answer given without a request.");

    a_wr_zero: assert property (
        sec_req.valid && sec_req.write
        |=> sec_rsp.rdata == 32'h0000_0000)
        else $error("Write answered with nonzero data.");

    a_setup2_hold: assert property (
        !(sec_req.valid && sec_req.write && sec_req.offset[11:2] == OFF_SU2[11:2])
        |=> $stable(su_q[0]))
        else $error("Window 2 setup changed without a secondary write.");

    a_setup3_hold: assert property (
        !(sec_req.valid && sec_req.write && sec_req.offset[11:2] == OFF_SU3[11:2])
        |=> $stable(su_q[1]))
        else $error("Window 3 setup changed without a secondary write.");

    a_setup_read: assert property (
        prim_req.valid && !prim_req.write && prim_req.offset[11:2] == OFF_SU2[11:2]
        |=> prim_rsp.rdata == $past(su_q[0]))
        else $error("Primary read of window 2 setup is wrong.");

    a_status_hit: assert property (
        dn_xout.valid && dn_xout.hit && !dn_xout.win3
        |=> status[`NDW_ST_WIN2])
        else $error("Window 2 hit not recorded in status.");

    a_status_miss: assert property (
        dn_xout.valid && !dn_xout.hit
        |=> status[`NDW_ST_MISS])
        else $error("Miss not recorded in status.");

    a_status_read: assert property (
        sec_req.valid && !sec_req.write && sec_req.offset[11:2] == OFF_ST[11:2]
        |=> sec_rsp.rdata == {29'h0000_0000, $past(status)})
        else $error("Status read does not return the current bits.");

    a_base_low: assert property (
        tb_q[0][11:0] == 12'h000 && tb_q[1][11:0] == 12'h000)
        else $error("Reserved base bits are not zero.");

    a_base2_hold: assert property (
        !(prim_req.valid && prim_req.write && prim_req.offset[11:2] == OFF_TB2[11:2])
        && !(sec_req.valid && sec_req.write && sec_req.offset[11:2] == OFF_TB2[11:2])
        |=> $stable(tb_q[0]))
        else $error("Window 2 base changed without a write.");

    a_base3_hold: assert property (
        !(prim_req.valid && prim_req.write && prim_req.offset[11:2] == OFF_TB3[11:2])
        && !(sec_req.valid && sec_req.write && sec_req.offset[11:2] == OFF_TB3[11:2])
        |=> $stable(tb_q[1]))
        else $error("Window 3 base changed without a write.");

    a_win2_mask: assert property (
        win2_cfg.size_mask == su_q[0][`NDW_SU_SIZE_HI:`NDW_SU_SIZE_LO])
        else $error("Window 2 size mask does not follow its setup.");

    a_win3_mask: assert property (
        win3_cfg.size_mask == su_q[1][`NDW_SU_SIZE_HI:`NDW_SU_SIZE_LO])
        else $error("Window 3 size mask does not follow its setup.");

    a_setup3_fixed: assert property (
        su_q[1][11:4] == 8'h00 && su_q[1][`NDW_SU_TYPE_HI] == 1'b0)
        else $error("Fixed window 3 setup bits are not zero.");

    a_prefetch_write: assert property (
        sec_req.valid && sec_req.write && sec_req.offset[11:2] == OFF_SU2[11:2]
        && sec_req.byte_en[0]
        |=> win2_cfg.prefetch == $past(sec_req.wdata[`NDW_SU_PREF]))
        else $error("Window 2 prefetch bit not taken from a write.");

    a_addr64_write: assert property (
        sec_req.valid && sec_req.write && sec_req.offset[11:2] == OFF_SU3[11:2]
        && sec_req.byte_en[0]
        |=> win3_cfg.addr64 == $past(sec_req.wdata[`NDW_SU_ADDR64]))
        else $error("Window 3 address type not taken from a write.");

    a_size2_write: assert property (
        sec_req.valid && sec_req.write && sec_req.offset[11:2] == OFF_SU2[11:2]
        && sec_req.byte_en == 4'hF
        |=> win2_cfg.size_mask == $past(sec_req.wdata[30:12]))
        else $error("Window 2 size mask not taken from a write.");

    a_enable_write: assert property (
        sec_req.valid && sec_req.write && sec_req.offset[11:2] == OFF_SU2[11:2]
        && sec_req.byte_en[3]
        |=> win2_cfg.enable == $past(sec_req.wdata[`NDW_SU_EN]))
        else $error("Window 2 enable not taken from a write.");

    a_hit_enabled: assert property (
        dn_req.valid && dn_req.win3 && win3_cfg.enable
        |=> dn_xout.valid && dn_xout.hit)
        else $error("Enabled window 3 did not report a hit.");

    a_xlate_quiet: assert property (
        !dn_req.valid
        |=> !dn_xout.valid)
        else $error("Translation answered without a request.");

    a_unmapped_zero: assert property (
        sec_req.valid && !sec_req.write && sel_a[1] == 5'h00
        |=> sec_rsp.rdata == 32'h0000_0000)
        else $error("Unmapped word did not read zero.");

endmodule

// ---- hw/ndw_xlate.sv ----
// Purpose: Replaces the window-covered address bits with the window's translated base.
// Assumes: The outer decoder has already picked the window that the address falls in.
// Notes:   Bit 31 is taken from the base whenever the window is enabled, so a window covers at most 2 GB.
`timescale 1ns/1ps
module ndw_xlate
    import ndw_pkg::*;
(
    input  wire logic            clk,
    input  wire logic            sys_rst,
    input  wire ndw_xreq_type    xreq,
    input  wire logic [31:0]     tbase2,
    input  wire logic [31:0]     tbase3,
    input  wire ndw_win_cfg_type cfg2,
    input  wire ndw_win_cfg_type cfg3,
    output ndw_xrsp_type         xrsp
);

    ndw_win_cfg_type sel_cfg;
    logic [31:0]     sel_tb;
    logic [31:0]     sel_mask;
    ndw_xrsp_type    next_xrsp;

    assign sel_cfg  = xreq.win3 ? cfg3 : cfg2;
    assign sel_tb   = xreq.win3 ? tbase3 : tbase2;
    assign sel_mask = {1'b1, sel_cfg.size_mask, 12'h000};

    assign next_xrsp.valid = xreq.valid;
    assign next_xrsp.hit   = xreq.valid & sel_cfg.enable;
    assign next_xrsp.win3  = xreq.win3;
    // A disabled window leaves the address alone and reports a miss instead.
    assign next_xrsp.addr  = sel_cfg.enable ? ((xreq.addr & ~sel_mask) | (sel_tb & sel_mask))
                                            : xreq.addr;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            xrsp <= '0;
        end else begin
            xrsp <= next_xrsp;
        end
    end

    a_xlate_win2: assert property (@(posedge clk) disable iff (sys_rst)
        xrsp.hit && !xrsp.win3 |->
        xrsp.addr == (($past(xreq.addr) & ~{1'b1, $past(cfg2.size_mask), 12'h000})
                      | ($past(tbase2) & {1'b1, $past(cfg2.size_mask), 12'h000})))
        else $error("Window 2 translation does not follow its size mask.");

    a_xlate_win3: assert property (@(posedge clk) disable iff (sys_rst)
        xrsp.hit && xrsp.win3 |->
        xrsp.addr == (($past(xreq.addr) & ~{1'b1, $past(cfg3.size_mask), 12'h000})
                      | ($past(tbase3) & {1'b1, $past(cfg3.size_mask), 12'h000})))
        else $error("Window 3 translation does not follow its size mask.");

    a_offset_kept: assert property (@(posedge clk) disable iff (sys_rst)
        xreq.valid |=> xrsp.valid && xrsp.addr[11:0] == $past(xreq.addr[11:0]))
        else $error("Offset bits changed by translation.");

endmodule

// ---- tb/ndw_port_master.sv ----
// Purpose: Bus master model for one bridge port of the window bank.
// Assumes: A request is launched on a falling edge and taken on the next rising edge.
// Notes:   Idle cycles carry a fresh random pattern so stale fields never pass for data.
`timescale 1ns/1ps
module ndw_port_master
    import ndw_pkg::*;
(
    input  wire logic clk,
    output ndw_req_type req
);
    integer seed;

    initial begin
        seed = 41;
        req  = '0;
    end

    task automatic access(input logic io, input logic wr, input logic [11:0] off,
                          input logic [31:0] wd, input logic [3:0] be);
        @(negedge clk);
        req <= '{valid: 1'b1, io_space: io, write: wr, offset: off, wdata: wd, byte_en: be};
        idle();
    endtask

    task automatic idle();
        @(negedge clk);
        req <= {1'b0, 50'({$random(seed), $random(seed)})};
    endtask
endmodule

// ---- tb/tb.sv ----
// Purpose: Self-checking bench of the downstream window bank.
// Assumes: Answers come one cycle after a request, so expectations are queued per port.
// Notes:   A monitor on the falling edge pops the oldest expectation for each answer.
`timescale 1ns/1ps
`include "ndw_defs.svh"
module tb
    import ndw_pkg::*;
;
    logic            clk;
    logic            sys_rst;
    ndw_req_type     prim_req;
    ndw_req_type     sec_req;
    ndw_rsp_type     prim_rsp;
    ndw_rsp_type     sec_rsp;
    ndw_xreq_type    dn_req;
    ndw_xrsp_type    dn_xout;
    ndw_win_cfg_type win2_cfg;
    ndw_win_cfg_type win3_cfg;
    integer          miscompares;
    integer          n_tests;
    integer          seed;
    logic [31:0]     qp[$];
    logic [31:0]     qs[$];
    logic [34:0]     qx[$];
    logic [31:0]     a;
    logic [31:0]     b2;
    logic [31:0]     b3;
    logic [31:0]     s2;
    logic [31:0]     s3;

    ndw_window_bank dut (.clk(clk), .sys_rst(sys_rst), .prim_req(prim_req), .sec_req(sec_req),
        .prim_rsp(prim_rsp), .sec_rsp(sec_rsp), .dn_req(dn_req), .dn_xout(dn_xout),
        .win2_cfg(win2_cfg), .win3_cfg(win3_cfg));
    ndw_port_master pm_p (.clk(clk), .req(prim_req));
    ndw_port_master pm_s (.clk(clk), .req(sec_req));

    task automatic chk(input logic [34:0] got, input logic [34:0] exp, input string what);
        n_tests++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic finish_test();
        if (qp.size() + qs.size() + qx.size() != 0) miscompares++;
        $display("Checks: %0d, mismatches: %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // Writes are always answered with zero data.
    task automatic xfer(input logic sec, input logic io, input logic wr, input logic [11:0] off,
                        input logic [31:0] wd, input logic [3:0] be, input logic [31:0] exp);
        if (sec) begin
            qs.push_back(wr ? 32'h0 : exp);
            pm_s.access(io, wr, off, wd, be);
        end else begin
            qp.push_back(wr ? 32'h0 : exp);
            pm_p.access(io, wr, off, wd, be);
        end
    endtask

    task automatic rd(input logic sec, input logic io, input logic [11:0] off,
                      input logic [31:0] exp);
        xfer(sec, io, 1'b0, off, $random(seed), 4'hF, exp);
    endtask

    task automatic xlate(input logic w3, input logic [31:0] adr, input logic [31:0] base,
                         input logic [31:0] su);
        logic [31:0] m;
        logic [31:0] e;
        m = {1'b1, su[30:12], 12'h000};
        e = su[31] ? ((adr & ~m) | (base & m)) : adr;
        qx.push_back({1'b1, su[31], w3, e});
        @(negedge clk);
        dn_req <= '{valid: 1'b1, win3: w3, addr: adr};
    endtask

    // Every group of requests ends here so that no request is held into the next group.
    task automatic quiet();
        fork
            pm_p.idle();
            pm_s.idle();
        join
        dn_req <= {2'b00, $random(seed)};
        repeat (3) @(negedge clk);
    endtask

    task automatic chk_cfg(input ndw_win_cfg_type got, input logic [31:0] su);
        chk(35'(got), 35'({su[31], su[30:12], su[3], su[1]}), "window configuration");
    endtask

    always @(negedge clk) begin
        if (sys_rst === 1'b0) begin
            if (prim_rsp.valid === 1'b1) begin
                if (qp.size() == 0) chk(35'h1, 35'h0, "unexpected primary answer");
                else chk(35'(prim_rsp.rdata), 35'(qp.pop_front()), "primary answer");
            end
            if (sec_rsp.valid === 1'b1) begin
                if (qs.size() == 0) chk(35'h1, 35'h0, "unexpected secondary answer");
                else chk(35'(sec_rsp.rdata), 35'(qs.pop_front()), "secondary answer");
            end
            if (dn_xout.valid === 1'b1) begin
                if (qx.size() == 0) chk(35'h1, 35'h0, "unexpected translation");
                else chk(35'(dn_xout), qx.pop_front(), "translation result");
            end
        end
    end

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    initial begin
        #20000;
        miscompares++;
        finish_test();
    end

    initial begin
        seed = 41;
        miscompares = 0;
        n_tests = 0;
        sys_rst = 1'b1;
        dn_req = '0;
        repeat (4) @(negedge clk);
        sys_rst = 1'b0;
        // Every offset one idle cycle apart, port alternating on each read and space on every second read, unmapped words included.
        for (int i = 0; i < 8; i++) rd(i[0], i[1], 12'(i * 4), 32'h0);
        a = $random(seed);
        b2 = a & 32'hFFFF_F000;
        xfer(1'b0, 1'b0, 1'b1, `NDW_OFF_TB2, a, 4'hF, 32'h0);
        rd(1'b1, 1'b1, `NDW_OFF_TB2, b2);
        a = $random(seed);
        b3 = a & 32'hFFFF_F000;
        xfer(1'b1, 1'b1, 1'b1, `NDW_OFF_TB3, a, 4'hF, 32'h0);
        rd(1'b0, 1'b0, `NDW_OFF_TB3, b3);
        xfer(1'b0, 1'b0, 1'b1, `NDW_OFF_SU2, 32'hFFFF_FFFF, 4'hF, 32'h0);
        rd(1'b1, 1'b0, `NDW_OFF_SU2, 32'h0);
        quiet();
        xlate(1'b0, $random(seed), b2, 32'h0);
        quiet();
        // Bits 0 and 2 are forced high on write to prove they cannot be set.
        s2 = ($random(seed) | 32'h8000_0007) & 32'hFFFF_F00A;
        s3 = ($random(seed) | 32'h8000_0005) & 32'hFFFF_F008;
        xfer(1'b1, 1'b0, 1'b1, `NDW_OFF_SU2, s2 | 32'h5, 4'hF, 32'h0);
        xfer(1'b1, 1'b1, 1'b1, `NDW_OFF_SU3, s3 | 32'h5, 4'hF, 32'h0);
        rd(1'b1, 1'b1, `NDW_OFF_SU2, s2);
        rd(1'b1, 1'b0, `NDW_OFF_SU3, s3);
        rd(1'b0, 1'b1, `NDW_OFF_SU2, s2);
        quiet();
        chk_cfg(win2_cfg, s2);
        chk_cfg(win3_cfg, s3);
        for (int i = 0; i < 6; i++) xlate(i[0], $random(seed), i[0] ? b3 : b2, i[0] ? s3 : s2);
        quiet();
        rd(1'b0, 1'b0, `NDW_OFF_STATUS, 32'h7);
        xfer(1'b1, 1'b0, 1'b1, `NDW_OFF_STATUS, 32'h5, 4'hF, 32'h0);
        rd(1'b0, 1'b1, `NDW_OFF_STATUS, 32'h2);
        xfer(1'b0, 1'b0, 1'b1, `NDW_OFF_STATUS, 32'h2, 4'hE, 32'h0);
        rd(1'b1, 1'b0, `NDW_OFF_STATUS, 32'h2);
        quiet();
        // A second reset in mid-run must clear every field, none of them is sticky.
        sys_rst = 1'b1;
        repeat (2) @(negedge clk);
        sys_rst = 1'b0;
        chk_cfg(win2_cfg, 32'h0);
        rd(1'b0, 1'b0, `NDW_OFF_TB2, 32'h0);
        rd(1'b1, 1'b0, `NDW_OFF_SU3, 32'h0);
        quiet();
        finish_test();
    end
endmodule
